// ==== dv/sie_far_model.sv ====
// Purpose: Behavioural far side of the engine: SIE events and bus lines.
// Assumes: Everything moves just after a rising edge of clock_in.
// Notes:   Event fields show inverted values once a pulse is over, so a
//          late sample cannot pass by luck.
`timescale 1ns/100ps
`default_nettype none
module sie_far_model
   import sie_ctrl_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       token_start_in,
   input  wire logic [3:0] token_pid_in,
   input  wire logic [3:0] token_endpoint_in,
   output var  logic       xact_done_out,
   output var  logic [3:0] xact_endpoint_out,
   output var  logic       xact_transmit_out,
   output var  logic       xact_odd_bank_out,
   output var  logic       setup_token_out,
   output var  logic       token_done_out,
   output var  logic       dp_line_out,
   output var  logic       dm_line_out
);
   int reply_delay = 2; // Cycles a token takes; raised by the bench

   // One transaction report, fields valid only in the pulse cycle
   task automatic pulse_xact(input logic [3:0] ep, input logic tx,
                             input logic odd, input logic tok);
      xact_done_out     <= 1'b1;
      token_done_out    <= tok;
      xact_endpoint_out <= ep;
      xact_transmit_out <= tx;
      xact_odd_bank_out <= odd;
      @(posedge clock_in);
      xact_done_out     <= 1'b0;
      token_done_out    <= 1'b0;
      xact_endpoint_out <= ~ep;
      xact_transmit_out <= ~tx;
      xact_odd_bank_out <= ~odd;
   endtask : pulse_xact

   // A received SETUP token, one cycle
   task automatic pulse_setup();
      setup_token_out <= 1'b1;
      @(posedge clock_in);
      setup_token_out <= 1'b0;
   endtask : pulse_setup

   // Line levels; J at full speed is D+ high
   task automatic set_lines(input logic p, input logic m);
      dp_line_out <= p;
      dm_line_out <= m;
   endtask : set_lines

   // Token execution: answer after a delay; IN receives, others transmit
   initial begin
      xact_done_out = 1'b0; token_done_out = 1'b0; setup_token_out = 1'b0;
      xact_endpoint_out = 4'h0; xact_transmit_out = 1'b0;
      xact_odd_bank_out = 1'b0; dp_line_out = 1'b1; dm_line_out = 1'b0;
      forever begin
         @(posedge clock_in);
         if (token_start_in === 1'b1) begin
            repeat (reply_delay) @(posedge clock_in);
            pulse_xact(token_endpoint_in, token_pid_in != PID_IN, 1'b0,
                       1'b1);
         end
      end
   end
endmodule : sie_far_model
`default_nettype wire

// ==== dv/usb_sie_control_status_tb_top.sv ====
// Purpose: Self-checking bench for the engine's control and status logic.
// Assumes: Zero-wait AHB-Lite slave; a short frame period in simulation.
// Notes:   Software timings of 10 ms and 50 ms are cut to a few cycles.
`timescale 1ns/100ps
`default_nettype none
module usb_sie_control_status_tb_top;
   import sie_ctrl_pkg::*;
   localparam int SOF_CYC = 20;
   logic        clock_in, resetn_in, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, xact_done, xact_tx, xact_odd, setup_tok;
   logic        token_done, dp_line, dm_line, pkt_dis, host_en, dp_pd, dm_pd;
   logic        dp_pu, dev_en, resume, pp_rst, bus_rst, low_spd, tok_start;
   logic        sof_tok;
   logic [3:0]  xact_ep, tok_pid, tok_ep;
   logic [6:0]  dev_addr;
   logic [7:0]  thresh;
   int          err_total = 0, n_compared = 0, cyc = 0, tok_cnt = 0;
   int          sof_cnt = 0, sof_last = 0, sof_gap = 0;

   sie_ctrl #(.SOF_PERIOD_CYCLES(SOF_CYC)) sie_ctrl_inst (
      .clock_in(clock_in), .resetn_in(resetn_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
      .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
      .xact_done_in(xact_done), .xact_endpoint_in(xact_ep),
      .xact_transmit_in(xact_tx), .xact_odd_bank_in(xact_odd),
      .setup_token_in(setup_tok), .token_done_in(token_done),
      .dp_line_in(dp_line), .dm_line_in(dm_line),
      .packet_processing_disable_out(pkt_dis),
      .host_capability_enable_out(host_en), .dp_pulldown_out(dp_pd),
      .dm_pulldown_out(dm_pd), .dp_pullup_out(dp_pu),
      .device_module_enable_out(dev_en), .resume_signal_out(resume),
      .pingpong_pointer_reset_out(pp_rst), .bus_reset_control_out(bus_rst),
      .low_speed_select_out(low_spd), .device_address_out(dev_addr),
      .token_start_out(tok_start), .token_pid_out(tok_pid),
      .token_endpoint_field_out(tok_ep), .frame_start_token_out(sof_tok),
      .threshold_value_out(thresh));

   sie_far_model sie_far_model_inst (
      .clock_in(clock_in), .token_start_in(tok_start),
      .token_pid_in(tok_pid), .token_endpoint_in(tok_ep),
      .xact_done_out(xact_done), .xact_endpoint_out(xact_ep),
      .xact_transmit_out(xact_tx), .xact_odd_bank_out(xact_odd),
      .setup_token_out(setup_tok), .token_done_out(token_done),
      .dp_line_out(dp_line), .dm_line_out(dm_line));

   // Clock, 10 ns period
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   // Pulse monitors: one-cycle outputs are counted at the edge
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (tok_start === 1'b1) tok_cnt <= tok_cnt + 1;
      if (sof_tok === 1'b1) begin
         sof_cnt  <= sof_cnt + 1;
         sof_gap  <= cyc - sof_last;
         sof_last <= cyc;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Single word transfer; waits for hready in both phases, bounded
   task automatic ahb(input logic wr, input logic [7:0] off,
                      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clock_in);
      hsel <= 1'b1; htrans <= HTRANS_NONSEQ_BIT; haddr <= {24'h0, off};
      hwrite <= wr; hsize <= 3'h2;
      n = 0;
      do begin @(posedge clock_in); n++; end
      while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0; hwdata <= wd;
      n = 0;
      do begin @(posedge clock_in); n++; end
      while (hreadyout !== 1'b1 && n < 50);
      rd = hrdata;
      if (n >= 50) chk("hready", 32'h1, 32'h0);
   endtask : ahb

   task automatic wr(input logic [7:0] off, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, off, d, r);
      @(negedge clock_in);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] off,
                         input logic [31:0] exp);
      logic [31:0] r;
      ahb(1'b0, off, WORD_ZERO, r);
      chk(what, exp, r);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : rd_chk

   // Reset values, unmapped place, address and threshold widths
   task automatic test_regs();
      rd_chk("status", OFF_STATUS, 32'h0);
      rd_chk("control", OFF_CONTROL, 32'h0);
      wr(8'h14, 32'hffff_ffff);
      rd_chk("unmapped", 8'h14, 32'h0);
      wr(OFF_ADDRESS, 32'hffff_ffff);
      rd_chk("address", OFF_ADDRESS, 32'h7f);
      chk("addr_out", 32'h7f, {25'h0, dev_addr});
      wr(OFF_THRESHOLD, 32'h1234_564a);
      rd_chk("threshold", OFF_THRESHOLD, 32'h4a);
      chk("thr_out", 32'h4a, {24'h0, thresh});
      $display("test_regs done");
   endtask : test_regs

   // Status fields loaded together, extremes of each field
   task automatic test_status();
      sie_far_model_inst.pulse_xact(4'hf, 1'b1, 1'b1, 1'b0);
      rd_chk("status_hi", OFF_STATUS, 32'hfc);
      sie_far_model_inst.pulse_xact(4'h0, 1'b0, 1'b0, 1'b0);
      rd_chk("status_lo", OFF_STATUS, 32'h00);
      sie_far_model_inst.pulse_xact(4'h6, 1'b0, 1'b1, 1'b0);
      rd_chk("status_mid", OFF_STATUS, 32'h64);
      $display("test_status done");
   endtask : test_status

   // Device mode controls, SETUP sets packet disable, live SE0, no token
   task automatic test_device();
      int t0;
      wr(OFF_CONTROL, 32'h37);
      rd_chk("dev_ctrl", OFF_CONTROL, 32'h27);
      chk("dev_outs", 32'h1f, {dp_pu, dev_en, resume, pp_rst,
          pkt_dis});
      chk("no_host", 32'h0, {bus_rst, host_en, dp_pd, dm_pd});
      wr(OFF_CONTROL, 32'h01);
      chk("pkt_clr", 32'h0, {31'h0, pkt_dis});
      sie_far_model_inst.pulse_setup();
      rd_chk("pkt_setup", OFF_CONTROL, 32'h21);
      sie_far_model_inst.set_lines(1'b0, 1'b0);
      repeat (5) @(posedge clock_in);
      rd_chk("se0_dev", OFF_CONTROL, 32'h61);
      sie_far_model_inst.set_lines(1'b1, 1'b0);
      t0 = tok_cnt;
      wr(OFF_TOKEN, {24'h0, PID_IN, 4'h3});
      repeat (4) @(posedge clock_in);
      chk("dev_token", t0, tok_cnt);
      wr(OFF_CONTROL, 32'h00);
      chk("detach", 32'h0, {dp_pu, dev_en});
      $display("test_device done");
   endtask : test_device

   // Host mode: pull-downs, J per speed, low-speed select
   task automatic test_host();
      wr(OFF_CONTROL, 32'h08);
      rd_chk("host_ctrl", OFF_CONTROL, 32'h88);
      chk("pulldowns", 32'h7, {host_en, dp_pd, dm_pd});
      chk("no_pullup", 32'h0, {31'h0, dp_pu});
      wr(OFF_ADDRESS, 32'h85);
      rd_chk("ls_addr", OFF_ADDRESS, 32'h85);
      chk("ls_out", 32'h1, {31'h0, low_spd});
      rd_chk("ls_not_j", OFF_CONTROL, 32'h08);
      sie_far_model_inst.set_lines(1'b0, 1'b1);
      repeat (5) @(posedge clock_in);
      rd_chk("ls_j", OFF_CONTROL, 32'h88);
      sie_far_model_inst.set_lines(1'b0, 1'b0);
      repeat (5) @(posedge clock_in);
      rd_chk("se0_host", OFF_CONTROL, 32'h48);
      sie_far_model_inst.set_lines(1'b1, 1'b0);
      wr(OFF_ADDRESS, 32'h05);
      $display("test_host done");
   endtask : test_host

   // Every token type, busy while executing, reserved code starts nothing
   task automatic test_tokens();
      logic [3:0] pids [3] = '{PID_SETUP, PID_IN, PID_OUT};
      int t0;
      sie_far_model_inst.reply_delay = 30;
      foreach (pids[i]) begin
         t0 = tok_cnt;
         wr(OFF_TOKEN, {24'h0, pids[i], 4'(i + 1)});
         @(negedge clock_in);
         chk("tok_start", t0 + 1, tok_cnt);
         chk("tok_fields", {pids[i], 4'(i + 1)}, {tok_pid, tok_ep});
         rd_chk("busy", OFF_CONTROL, 32'ha8);
         repeat (35) @(posedge clock_in);
         rd_chk("idle", OFF_CONTROL, 32'h88);
         rd_chk("tok_status", OFF_STATUS,
                {24'h0, 4'(i + 1), pids[i] != PID_IN, 3'h0});
      end
      t0 = tok_cnt;
      wr(OFF_TOKEN, 32'h25);
      repeat (4) @(posedge clock_in);
      chk("reserved", t0, tok_cnt);
      $display("test_tokens done");
   endtask : test_tokens

   // Bus reset holds off frames; frame tokens every period while enabled
   task automatic test_frames();
      int s0;
      wr(OFF_CONTROL, 32'h19);
      s0 = sof_cnt;
      repeat (3 * SOF_CYC) @(posedge clock_in);
      chk("bus_rst", 32'h1, {31'h0, bus_rst});
      chk("sof_in_rst", s0, sof_cnt);
      wr(OFF_CONTROL, 32'h09);
      chk("rst_end", 32'h0, {31'h0, bus_rst});
      s0 = sof_cnt;
      repeat (4 * SOF_CYC) @(posedge clock_in);
      chk("sof_seen", 32'h1, {31'h0, sof_cnt - s0 >= 3});
      chk("sof_gap", SOF_CYC, sof_gap);
      wr(OFF_CONTROL, 32'h08);
      s0 = sof_cnt;
      repeat (3 * SOF_CYC) @(posedge clock_in);
      chk("sof_off", s0, sof_cnt);
      $display("test_frames done");
   endtask : test_frames

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      resetn_in = 1'b0; hsel = 1'b0; haddr = WORD_ZERO; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = WORD_ZERO;
      repeat (5) @(posedge clock_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      test_regs();
      test_status();
      test_device();
      test_host();
      test_tokens();
      test_frames();
      report_and_stop();
   end

   // Watchdog, well beyond the few hundred cycles the tests take
   initial begin
      repeat (20000) @(posedge clock_in);
      err_total++;
      report_and_stop();
   end
endmodule : usb_sie_control_status_tb_top
`default_nettype wire

// ==== rtl/sie_ctrl.sv ====
// Purpose: Control and status registers of a USB OTG serial interface
//          engine, reached over AHB-Lite.
// Assumes: SIE handshakes arrive on clock_in; D+/D- levels are async.
// Notes:   Zero-wait slave; read data registered in the address phase.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - After each transfer, load last endpoint number, 0 to 15.
// - Transmit indicator is one for transmit, zero for receive.
// - Bank indicator is one for odd bank, zero for even bank.
// - Bank indicator meaningful only for endpoints with both banks.
// - Live single-ended zero flag, read-only, in both modes.
// - Packet disable stops processing; set by hardware on SETUP tokens in device mode.
// - Host enable turns on host operation and both D+/D- pull-downs.
// - Resume signaling driven while resume bit set; software times 10 ms.
// - Ping-pong reset returns all buffer pointers to the even bank.
// - Device mode enable turns on module and D+ pull-up.
// - Host mode shows live J state flag, speed dependent.
// - Host token busy flag high while a token executes.
// - Bus reset driven while control set; software holds 50 ms.
// - Start-of-frame token sent every millisecond while enabled; none sent while bus reset is set.
// - Low-speed select in host mode; reads zero in device mode.
// - Seven-bit device address, readable and writable.
// - Token types SETUP 1101, IN 1001, OUT 0001; others reserved.
// - Eight-bit frame threshold equals ten plus packet size.
// - Unimplemented bits and upper bytes read zero, ignore writes.
// - Only the least significant byte of each register exists.
module sie_ctrl
   import sie_ctrl_pkg::*;
#(
   parameter int SOF_PERIOD_CYCLES = SOF_PERIOD_CYC
) (
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output var  logic [31:0] hrdata_out,
   output var  logic        hreadyout_out,
   output var  logic        hresp_out,
   // SIE events, same clock
   input  wire logic        xact_done_in,
   input  wire logic [3:0]  xact_endpoint_in,
   input  wire logic        xact_transmit_in,
   input  wire logic        xact_odd_bank_in,
   input  wire logic        setup_token_in,
   input  wire logic        token_done_in,
   // Bus line levels, asynchronous
   input  wire logic        dp_line_in,
   input  wire logic        dm_line_in,
   // Controls to SIE and transceiver
   output var  logic        packet_processing_disable_out,
   output var  logic        host_capability_enable_out,
   output var  logic        dp_pulldown_out,
   output var  logic        dm_pulldown_out,
   output var  logic        dp_pullup_out,
   output var  logic        device_module_enable_out,
   output var  logic        resume_signal_out,
   output var  logic        pingpong_pointer_reset_out,
   output var  logic        bus_reset_control_out,
   output var  logic        low_speed_select_out,
   output var  logic [6:0]  device_address_out,
   output var  logic        token_start_out,
   output var  logic [3:0]  token_pid_out,
   output var  logic [3:0]  token_endpoint_field_out,
   output var  logic        frame_start_token_out,
   output var  logic [7:0]  threshold_value_out
);

   localparam int SOF_W = $clog2(SOF_PERIOD_CYCLES + 1);
   localparam logic [SOF_W-1:0] SOF_LAST = SOF_W'(SOF_PERIOD_CYCLES - 1);
   localparam logic [SOF_W-1:0] SOF_ZERO = '0;

   typedef struct packed {
      logic             dp_s1;
      logic             dp_s2;
      logic             dm_s1;
      logic             dm_s2;
      logic             se0;
      logic             jst;
      logic             wr_pend;
      reg_sel_t         wr_sel;
      logic [31:0]      rdata;
      logic             ready;
      logic [3:0]       last_ep;
      logic             last_tx;
      logic             last_odd;
      logic             pkt_dis;
      logic             host_en;
      logic             resume;
      logic             pp_rst;
      logic             mod_en;
      logic             bus_rst;
      logic             sof_en;
      logic             tok_busy;
      logic             tok_start;
      logic [7:0]       tok_cmd;
      logic             low_speed;
      logic [6:0]       dev_addr;
      logic [7:0]       sof_thr;
      logic [SOF_W-1:0] sof_cnt;
      logic             sof_pulse;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // Maps a byte address to a register selector
   function automatic reg_sel_t decode_reg(input logic [31:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr[31:8] == 24'h00_0000) begin
         unique case (addr[7:0])
            OFF_STATUS:    sel = SEL_STATUS;
            OFF_CONTROL:   sel = SEL_CONTROL;
            OFF_ADDRESS:   sel = SEL_ADDRESS;
            OFF_TOKEN:     sel = SEL_TOKEN;
            OFF_THRESHOLD: sel = SEL_THRESHOLD;
            default:       sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction : decode_reg

   // Legal host token type check
   function automatic logic pid_legal(input logic [3:0] pid);
      return (pid == PID_SETUP) || (pid == PID_IN) || (pid == PID_OUT);
   endfunction : pid_legal

   // Next-state logic
   always_comb begin
      logic       take;
      logic [7:0] wb;
      logic [7:0] rb;
      reg_sel_t   rsel;
      take = 1'b0;
      wb   = BYTE_ZERO;
      rb   = BYTE_ZERO;
      rsel = SEL_NONE;
      state_next = state_reg;

      // Two-stage synchronisers; only stage two feeds logic
      state_next.dp_s1 = dp_line_in;
      state_next.dp_s2 = state_reg.dp_s1;
      state_next.dm_s1 = dm_line_in;
      state_next.dm_s2 = state_reg.dm_s1;
      state_next.se0 = ~state_reg.dp_s2 & ~state_reg.dm_s2;
      // J is D+ high at full speed, D- high at low speed
      state_next.jst = state_reg.host_en &
         (state_reg.low_speed ? (~state_reg.dp_s2 & state_reg.dm_s2)
                              : (state_reg.dp_s2 & ~state_reg.dm_s2));

      state_next.tok_start = 1'b0;
      state_next.sof_pulse = 1'b0;
      state_next.ready     = 1'b1;

      // Data phase of a write: only the low byte is kept
      wb = hwdata_in[7:0];
      if (state_reg.wr_pend) begin
         unique case (state_reg.wr_sel)
            SEL_CONTROL: begin
               state_next.host_en = wb[CT_HOST_BIT];
               state_next.resume  = wb[CT_RESUME_BIT];
               state_next.pp_rst  = wb[CT_PPRST_BIT];
               if (state_reg.host_en) begin
                  state_next.bus_rst = wb[CT_BRST_BIT];
                  state_next.sof_en  = wb[CT_EN_BIT];
               end else begin
                  state_next.pkt_dis = wb[CT_PACKET_PROCESSING_DISABLE_BIT];
                  state_next.mod_en  = wb[CT_EN_BIT];
               end
            end
            SEL_ADDRESS: begin
               state_next.dev_addr  = wb[6:0];
               state_next.low_speed = wb[AD_LS_BIT] &
                                      state_reg.host_en;
            end
            SEL_TOKEN: begin
               // A new token is refused while one is in progress
               if (state_reg.host_en && !state_reg.tok_busy) begin
                  state_next.tok_cmd = wb;
                  if (pid_legal(wb[7:TK_PID_LSB])) begin
                     state_next.tok_busy  = 1'b1;
                     state_next.tok_start = 1'b1;
                  end
               end
            end
            SEL_THRESHOLD: state_next.sof_thr = wb;
            default: ;
         endcase
      end

      // Leaving host mode drops the host-only controls
      if (!state_next.host_en) begin
         state_next.bus_rst   = 1'b0;
         state_next.sof_en    = 1'b0;
         state_next.low_speed = 1'b0;
      end

      // Hardware events win over software clears
      if (setup_token_in && !state_reg.host_en) begin
         state_next.pkt_dis = 1'b1;
      end
      if (token_done_in && !state_next.tok_start) begin
         state_next.tok_busy = 1'b0;
      end
      if (!state_next.host_en) begin
         state_next.tok_busy = 1'b0;
      end

      // All three transfer fields load together
      if (xact_done_in) begin
         state_next.last_ep  = xact_endpoint_in;
         state_next.last_tx  = xact_transmit_in;
         state_next.last_odd = xact_odd_bank_in;
      end

      // Frame timer runs only while frames are enabled
      if (state_reg.host_en && state_reg.sof_en && !state_reg.bus_rst) begin
         if (state_reg.sof_cnt == SOF_LAST) begin
            state_next.sof_cnt   = SOF_ZERO;
            state_next.sof_pulse = 1'b1;
         end else begin
            state_next.sof_cnt = state_reg.sof_cnt + 1'b1;
         end
      end else begin
         state_next.sof_cnt = SOF_ZERO;
      end

      // Address phase: capture write, or build read data from new state
      take = hsel_in & hready_in & htrans_in[1] & (htrans_in[0] == 1'b0 ||
             htrans_in == (HTRANS_NONSEQ_BIT | 2'h1));
      rsel = decode_reg(haddr_in);
      state_next.wr_pend = take & hwrite_in;
      state_next.wr_sel  = rsel;
      unique case (rsel)
         SEL_STATUS:
            rb = {state_next.last_ep, state_next.last_tx,
                  state_next.last_odd, 2'b00};
         SEL_CONTROL:
            if (state_next.host_en) begin
               rb = {state_next.jst, state_next.se0, state_next.tok_busy,
                     state_next.bus_rst, 1'b1, state_next.resume,
                     state_next.pp_rst, state_next.sof_en};
            end else begin
               rb = {1'b0, state_next.se0, state_next.pkt_dis, 1'b0,
                     1'b0, state_next.resume, state_next.pp_rst,
                     state_next.mod_en};
            end
         SEL_ADDRESS:   rb = {state_next.low_speed, state_next.dev_addr};
         SEL_TOKEN:     rb = state_next.tok_cmd;
         SEL_THRESHOLD: rb = state_next.sof_thr;
         default:       rb = BYTE_ZERO;
      endcase
      if (take && !hwrite_in) begin
         state_next.rdata = {24'h00_0000, rb};
      end
   end

   // State register; constants only under reset
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from state flops; hresp_out tied to zero
   assign hrdata_out                    = state_reg.rdata;
   assign hreadyout_out                 = state_reg.ready;
   assign hresp_out                     = 1'b0;
   assign packet_processing_disable_out = state_reg.pkt_dis;
   assign host_capability_enable_out    = state_reg.host_en;
   assign dp_pulldown_out               = state_reg.host_en;
   assign dm_pulldown_out               = state_reg.host_en;
   assign dp_pullup_out                 = state_reg.mod_en;
   assign device_module_enable_out      = state_reg.mod_en;
   assign resume_signal_out             = state_reg.resume;
   assign pingpong_pointer_reset_out    = state_reg.pp_rst;
   assign bus_reset_control_out         = state_reg.bus_rst;
   assign low_speed_select_out          = state_reg.low_speed;
   assign device_address_out            = state_reg.dev_addr;
   assign token_start_out               = state_reg.tok_start;
   assign token_pid_out                 = state_reg.tok_cmd[7:TK_PID_LSB];
   assign token_endpoint_field_out      = state_reg.tok_cmd[3:0];
   assign frame_start_token_out         = state_reg.sof_pulse;
   assign threshold_value_out           = state_reg.sof_thr;

   // Checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   sequence ctl_write_s(int b);
      state_reg.wr_pend && state_reg.wr_sel == SEL_CONTROL && hwdata_in[b];
   endsequence

   sequence tok_write_s;
      state_reg.wr_pend && state_reg.wr_sel == SEL_TOKEN
      && host_capability_enable_out && !state_reg.tok_busy
      && pid_legal(hwdata_in[7:TK_PID_LSB]);
   endsequence

   status_load_a: assert property (
      xact_done_in |=> state_reg.last_ep == $past(xact_endpoint_in)
         && state_reg.last_tx == $past(xact_transmit_in)
         && state_reg.last_odd == $past(xact_odd_bank_in))
      else $error("status fields not loaded together");

   setup_disable_a: assert property (
      setup_token_in && !host_capability_enable_out
         |=> packet_processing_disable_out)
      else $error("setup did not disable packets");

   host_pulldown_a: assert property (
      ctl_write_s(CT_HOST_BIT) |=> dp_pulldown_out && dm_pulldown_out)
      else $error("host enable did not pull down lines");

   resume_drive_a: assert property (
      ctl_write_s(CT_RESUME_BIT) |=> resume_signal_out)
      else $error("resume not driven");

   pullup_device_a: assert property (
      ctl_write_s(CT_EN_BIT) ##0 !host_capability_enable_out
         |=> dp_pullup_out)
      else $error("pull-up not on after enable");

   line_se0_a: assert property (
      (!dp_line_in && !dm_line_in) [*4] |-> state_reg.se0)
      else $error("single-ended zero not seen");

   token_busy_a: assert property (
      tok_write_s |=> token_start_out && state_reg.tok_busy
         ##1 !token_start_out)
      else $error("token busy not raised");

   frame_gap_a: assert property (
      frame_start_token_out |=> !frame_start_token_out [*8])
      else $error("start-of-frame repeated too soon");

   frame_off_a: assert property (
      !(state_reg.host_en && state_reg.sof_en) |=> !frame_start_token_out)
      else $error("start-of-frame while disabled");

   speed_device_a: assert property (
      !host_capability_enable_out |-> !low_speed_select_out)
      else $error("low speed set in device mode");

   reset_host_a: assert property (
      bus_reset_control_out |-> host_capability_enable_out)
      else $error("bus reset outside host mode");

   addr_store_a: assert property (
      state_reg.wr_pend && state_reg.wr_sel == SEL_ADDRESS
         |=> device_address_out == $past(hwdata_in[6:0]))
      else $error("device address not stored");

   upper_zero_a: assert property (
      hrdata_out[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");

endmodule : sie_ctrl

`default_nettype wire

// ==== rtl/sie_ctrl_pkg.sv ====
// Purpose: Shared constants for the USB serial interface engine control
//          and status registers.
// Assumes: 32-bit AHB-Lite data, one aligned word per register.
// Notes:   Only the low byte of each register carries state.
package sie_ctrl_pkg;

   // Clock and timing
   localparam int CLOCK_MHZ       = 100;
   localparam int SOF_PERIOD_US   = 1000;
   localparam int SOF_PERIOD_CYC  = SOF_PERIOD_US * CLOCK_MHZ;

   // Register byte offsets
   localparam logic [7:0] OFF_STATUS    = 8'h00;
   localparam logic [7:0] OFF_CONTROL   = 8'h04;
   localparam logic [7:0] OFF_ADDRESS   = 8'h08;
   localparam logic [7:0] OFF_TOKEN     = 8'h0c;
   localparam logic [7:0] OFF_THRESHOLD = 8'h10;

   // Decoded register selector
   typedef enum logic [2:0] {
      SEL_STATUS, SEL_CONTROL, SEL_ADDRESS, SEL_TOKEN, SEL_THRESHOLD,
      SEL_NONE
   } reg_sel_t;

   // Status field positions
   localparam int ST_EP_LSB   = 4;
   localparam int ST_TX_BIT   = 3;
   localparam int ST_BANK_BIT = 2;

   // Control field positions
   localparam int CT_J_BIT      = 7;
   localparam int CT_SE0_BIT    = 6;
   localparam int CT_PACKET_PROCESSING_DISABLE_BIT = 5;
   localparam int CT_TBUSY_BIT  = 5;
   localparam int CT_BRST_BIT   = 4;
   localparam int CT_HOST_BIT   = 3;
   localparam int CT_RESUME_BIT = 2;
   localparam int CT_PPRST_BIT  = 1;
   localparam int CT_EN_BIT     = 0;

   // Address and token field positions
   localparam int AD_LS_BIT   = 7;
   localparam int TK_PID_LSB  = 4;

   // Token type codes
   localparam logic [3:0] PID_SETUP = 4'hd;
   localparam logic [3:0] PID_IN    = 4'h9;
   localparam logic [3:0] PID_OUT   = 4'h1;

   // Reset values and widths
   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;

endpackage : sie_ctrl_pkg
